// *** rtl/rsm_consts.svh ***
`ifndef RSM_CONSTS_SVH
`define RSM_CONSTS_SVH

// Wire-level protocol addresses (register number minus one).
`define RSM_ADDR_STATION     16'h0000
`define RSM_ADDR_LINK        16'h0001
`define RSM_ADDR_SERIAL      16'h0000
`define RSM_SERIAL_WORDS     8
`define RSM_ADDR_FIRMWARE    16'h0008
`define RSM_ADDR_LABEL       16'h0009
`define RSM_LABEL_WORDS      8
`define RSM_ADDR_STATUS      16'h0259
`define RSM_ADDR_MAP_BASE    16'h0bb8
`define RSM_MAP_SLOTS_MAX    20
`define RSM_ADDR_MAP_CFG     16'h0bd0

// Float pairs: high word at the address, low word at address plus one.
`define RSM_F_TEMP_C         16'h03ea
`define RSM_F_TEMP_F         16'h03ec
`define RSM_F_TEMP_K         16'h03f0
`define RSM_F_HUMID          16'h03fc
`define RSM_F_CO2_AVG        16'h0424
`define RSM_F_CO2_RAW        16'h0426
`define RSM_F_DEW_C          16'h0450
`define RSM_F_DEW_F          16'h0452
`define RSM_F_DEW_K          16'h047a

`define RSM_S_TEMP_C         16'h0fa1
`define RSM_S_TEMP_F         16'h0fa2
`define RSM_S_TEMP_K         16'h0fa4
`define RSM_S_HUMID          16'h0faa
`define RSM_S_CO2_AVG        16'h0fbe
`define RSM_S_CO2_RAW        16'h0fbf
`define RSM_S_DEW_C          16'h0fd4
`define RSM_S_DEW_F          16'h0fd5
`define RSM_S_DEW_K          16'h0fe9

`define RSM_SCALE_100        8'h64
`define RSM_SCALE_50         8'h32
`define RSM_SCALE_1          8'h01

`define RSM_MEAS_COUNT       9
`define RSM_FRAC_BITS        8
`define RSM_ROUND_HALF       48'sh80
`define RSM_PAIR_STEP        16'h0001

// Switch bank value that hands the bus address back to the stored one.
`define RSM_SWITCH_OFF       8'h00

// Station address: reset value and Modbus legal range.
`define RSM_STATION_RESET    8'h2d
`define RSM_STATION_MIN      16'h0001
`define RSM_STATION_MAX      16'h00f7

// Link settings word layout.
`define RSM_LS_BAUD_LSB      0
`define RSM_LS_BAUD_MSB      2
`define RSM_LS_PAR_LSB       3
`define RSM_LS_PAR_MSB       4
`define RSM_LS_STOP2         5
`define RSM_BAUD_MAX_IDX     3'h5
`define RSM_PAR_MAX          2'h2

// Function codes and exception codes.
`define RSM_FC_READ_HOLD     8'h03
`define RSM_FC_READ_INPUT    8'h04
`define RSM_FC_WRITE_SINGLE  8'h06
`define RSM_EX_NONE          8'h00
`define RSM_EX_FUNC          8'h01
`define RSM_EX_ADDR          8'h02
`define RSM_EX_VALUE         8'h03

`endif

// *** rtl/rsm_pkg.sv ***
package rsm_pkg;

	typedef enum logic [1:0] {
		RSM_PAR_NONE,
		RSM_PAR_ODD,
		RSM_PAR_EVEN
	} rsm_parity_t;

	typedef enum logic [2:0] {
		RSM_BAUD_9600,
		RSM_BAUD_19200,
		RSM_BAUD_38400,
		RSM_BAUD_57600,
		RSM_BAUD_76800,
		RSM_BAUD_115200
	} rsm_baud_t;

endpackage

// *** rtl/rsm_register_bank.sv ***
`timescale 1ns/1ps
`include "rsm_consts.svh"

module rsm_register_bank #(
	parameter int              MAP_SLOTS   = 20,
	parameter logic [2:0]      BAUD_RESET  = 3'h0,
	parameter logic [127:0]    SERIAL_TEXT = 128'h30303030303030303030303030303031,
	parameter logic [127:0]    LABEL_TEXT  = 128'h53454e534f522020202020202020202,
	parameter logic [7:0]      FW_MAJOR    = 8'h01,
	parameter logic [7:0]      FW_MINOR    = 8'h00
) (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic [7:0]          addrSwitch,
	input  wire logic                bacnetMode,
	input  wire logic                reqValid,
	input  wire logic [7:0]          reqFunc,
	input  wire logic [15:0]         reqAddr,
	input  wire logic [15:0]         reqData,
	input  wire logic [31:0]         measFloat [`RSM_MEAS_COUNT],
	input  wire logic signed [31:0]  measFixed [`RSM_MEAS_COUNT],
	input  wire logic [15:0]         statusFlags,
	output logic                     rspValid,
	output logic [15:0]              rspData,
	output logic [7:0]               rspException,
	output logic [7:0]               busAddress,
	output rsm_pkg::rsm_baud_t       baudSel,
	output rsm_pkg::rsm_parity_t     parityMode,
	output logic                     twoStopBits
);

	if (MAP_SLOTS < 1 || MAP_SLOTS > `RSM_MAP_SLOTS_MAX) begin
		$error("MAP_SLOTS must lie between 1 and 20");
	end

	if (BAUD_RESET > `RSM_BAUD_MAX_IDX) begin
		$error("BAUD_RESET must name one of the six line rates");
	end

	logic [7:0]          station_r;
	logic [15:0]         link_r;
	logic [15:0]         mapSel_r [MAP_SLOTS];
	logic signed [15:0]  scaled_r [`RSM_MEAS_COUNT];
	logic                rspValid_r;
	logic [15:0]         rspData_r;
	logic [7:0]          rspExc_r;

	function automatic logic [15:0] floatOffset(input int idx);
		case (idx)
			0:       floatOffset = `RSM_F_TEMP_C;
			1:       floatOffset = `RSM_F_TEMP_F;
			2:       floatOffset = `RSM_F_TEMP_K;
			3:       floatOffset = `RSM_F_HUMID;
			4:       floatOffset = `RSM_F_CO2_AVG;
			5:       floatOffset = `RSM_F_CO2_RAW;
			6:       floatOffset = `RSM_F_DEW_C;
			7:       floatOffset = `RSM_F_DEW_F;
			default: floatOffset = `RSM_F_DEW_K;
		endcase
	endfunction

	function automatic logic [15:0] scaledOffset(input int idx);
		case (idx)
			0:       scaledOffset = `RSM_S_TEMP_C;
			1:       scaledOffset = `RSM_S_TEMP_F;
			2:       scaledOffset = `RSM_S_TEMP_K;
			3:       scaledOffset = `RSM_S_HUMID;
			4:       scaledOffset = `RSM_S_CO2_AVG;
			5:       scaledOffset = `RSM_S_CO2_RAW;
			6:       scaledOffset = `RSM_S_DEW_C;
			7:       scaledOffset = `RSM_S_DEW_F;
			default: scaledOffset = `RSM_S_DEW_K;
		endcase
	endfunction

	function automatic logic [7:0] scaleOf(input int idx);
		case (idx)
			1, 2:    scaleOf = `RSM_SCALE_50;
			4, 5:    scaleOf = `RSM_SCALE_1;
			default: scaleOf = `RSM_SCALE_100;
		endcase
	endfunction

	// Inputs carry RSM_FRAC_BITS fraction bits; rounding is half up, then clamped.
	function automatic logic signed [15:0] scaleRound(input logic signed [31:0] v,
		input logic [7:0] s);
		logic signed [47:0] prod;
		logic signed [47:0] q;
		prod = 48'(v) * 48'(signed'({1'b0, s}));
		q = (prod + `RSM_ROUND_HALF) >>> `RSM_FRAC_BITS;
		if (q > 48'sh7fff) begin
			scaleRound = 16'sh7fff;
		end else if (q < -48'sh8000) begin
			scaleRound = -16'sh8000;
		end else begin
			scaleRound = q[15:0];
		end
	endfunction

	// Two characters per word, the first character in the high byte.
	function automatic logic [15:0] textWord(input logic [127:0] t, input logic [2:0] w);
		textWord = t[127 - 16 * w -: 16];
	endfunction

	// True when a lies in the MAP_SLOTS words that start at base.
	function automatic logic inBlock(input logic [15:0] a, input logic [15:0] base);
		logic [15:0] idx;
		idx = a - base;
		inBlock = (a >= base) && (idx < 16'(MAP_SLOTS));
	endfunction

	// Slot number inside a block; only meaningful where inBlock holds.
	function automatic logic [4:0] slotOf(input logic [15:0] a, input logic [15:0] base);
		logic [15:0] idx;
		idx = a - base;
		slotOf = idx[4:0];
	endfunction

	// Identity text, firmware and status words.
	function automatic logic [16:0] identityWord(input logic [15:0] a);
		logic [15:0] off;
		off = 16'h0000;
		identityWord = 17'h00000;
		if (a < `RSM_ADDR_SERIAL + 16'(`RSM_SERIAL_WORDS)) begin
			off = a - `RSM_ADDR_SERIAL;
			identityWord = {1'b1, textWord(SERIAL_TEXT, off[2:0])};
		end else if (a == `RSM_ADDR_FIRMWARE) begin
			identityWord = {1'b1, FW_MAJOR, FW_MINOR};
		end else if (a >= `RSM_ADDR_LABEL &&
			a < `RSM_ADDR_LABEL + 16'(`RSM_LABEL_WORDS)) begin
			off = a - `RSM_ADDR_LABEL;
			identityWord = {1'b1, textWord(LABEL_TEXT, off[2:0])};
		end else if (a == `RSM_ADDR_STATUS) begin
			identityWord = {1'b1, statusFlags};
		end
	endfunction

	// High word of a float pair at its address, low word one above.
	function automatic logic [16:0] floatWord(input logic [15:0] a);
		floatWord = 17'h00000;
		for (int i = 0; i < `RSM_MEAS_COUNT; i++) begin
			if (a == floatOffset(i)) begin
				floatWord = {1'b1, measFloat[i][31:16]};
			end
			if (a == floatOffset(i) + `RSM_PAIR_STEP) begin
				floatWord = {1'b1, measFloat[i][15:0]};
			end
		end
	endfunction

	// Scaled words come from the registered copies, one cycle behind the inputs.
	function automatic logic [16:0] scaledWord(input logic [15:0] a);
		scaledWord = 17'h00000;
		for (int i = 0; i < `RSM_MEAS_COUNT; i++) begin
			if (a == scaledOffset(i)) begin
				scaledWord = {1'b1, scaled_r[i]};
			end
		end
	endfunction

	// Plain map lookup; valid is low for an unmapped address.
	function automatic logic [16:0] lookup(input logic [15:0] a);
		logic [16:0] ident;
		logic [16:0] flt;
		logic [16:0] scl;
		ident  = identityWord(a);
		flt    = floatWord(a);
		scl    = scaledWord(a);
		lookup = 17'h00000;
		if (ident[16]) begin
			lookup = ident;
		end else if (flt[16]) begin
			lookup = flt;
		end else if (scl[16]) begin
			lookup = scl;
		end else if (inBlock(a, `RSM_ADDR_MAP_CFG)) begin
			lookup = {1'b1, mapSel_r[slotOf(a, `RSM_ADDR_MAP_CFG)]};
		end
	endfunction

	// Mapped slots mirror one level only, so a slot pointing at a slot reads invalid.
	function automatic logic [16:0] readWord(input logic [15:0] a);
		if (inBlock(a, `RSM_ADDR_MAP_BASE)) begin
			readWord = lookup(mapSel_r[slotOf(a, `RSM_ADDR_MAP_BASE)]);
		end else begin
			readWord = lookup(a);
		end
	endfunction

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < `RSM_MEAS_COUNT; i++) begin
				scaled_r[i] <= 16'sh0000;
			end
		end else begin
			for (int i = 0; i < `RSM_MEAS_COUNT; i++) begin
				scaled_r[i] <= scaleRound(measFixed[i], scaleOf(i));
			end
		end
	end

	// Modbus station numbers run from 1 to 247; 0 is the broadcast address.
	function automatic logic stationValid(input logic [15:0] d);
		stationValid = d >= `RSM_STATION_MIN && d <= `RSM_STATION_MAX;
	endfunction

	// Unused upper bits of the settings word are stored but change nothing.
	function automatic logic linkValid(input logic [15:0] d);
		linkValid = d[`RSM_LS_BAUD_MSB:`RSM_LS_BAUD_LSB] <= `RSM_BAUD_MAX_IDX &&
			d[`RSM_LS_PAR_MSB:`RSM_LS_PAR_LSB] <= `RSM_PAR_MAX;
	endfunction

	localparam logic [15:0] LINK_RESET = 16'({1'b0, 2'(rsm_pkg::RSM_PAR_EVEN), BAUD_RESET});

	// Request decode, shared by the write targets and the answer.
	logic        isWrite;
	logic        isRead;
	logic        isOther;
	logic        wrStation;
	logic        wrLink;
	logic        wrMap;
	logic        cfgHit;
	logic [4:0]  cfgSlot;
	logic        linkOk;
	logic        stationOk;
	logic [16:0] rdWord;
	logic [15:0] rdData;
	logic        rdHit;
	logic [7:0]  rdExc;
	logic [7:0]  wrExc;
	logic        switchesZero;

	assign isWrite   = reqValid && reqFunc == `RSM_FC_WRITE_SINGLE;
	assign isRead    = reqValid && (reqFunc == `RSM_FC_READ_HOLD ||
		reqFunc == `RSM_FC_READ_INPUT);
	assign isOther   = reqValid && !isWrite && !isRead;
	assign cfgHit    = inBlock(reqAddr, `RSM_ADDR_MAP_CFG);
	assign cfgSlot   = slotOf(reqAddr, `RSM_ADDR_MAP_CFG);
	assign stationOk = stationValid(reqData);
	assign linkOk    = linkValid(reqData);
	assign wrStation = isWrite && reqAddr == `RSM_ADDR_STATION;
	assign wrLink    = isWrite && reqAddr == `RSM_ADDR_LINK;
	assign wrMap     = isWrite && cfgHit;
	assign rdWord    = readWord(reqAddr);
	assign rdData    = rdWord[15:0];
	assign rdHit     = rdWord[16];
	// Unmapped reads answer with an address error and a zero data word.
	assign rdExc     = rdHit ? `RSM_EX_NONE : `RSM_EX_ADDR;

	// Writes outside the two settings words and the map table are refused, identity included.
	always_comb begin
		if (reqAddr == `RSM_ADDR_STATION) begin
			wrExc = stationOk ? `RSM_EX_NONE : `RSM_EX_VALUE;
		end else if (reqAddr == `RSM_ADDR_LINK) begin
			wrExc = linkOk ? `RSM_EX_NONE : `RSM_EX_VALUE;
		end else if (cfgHit) begin
			wrExc = `RSM_EX_NONE;
		end else begin
			wrExc = `RSM_EX_ADDR;
		end
	end

	// A refused value leaves the stored address as it was.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			station_r <= `RSM_STATION_RESET;
		end else if (wrStation && stationOk) begin
			station_r <= reqData[7:0];
		end
	end

	// BAUD_RESET picks the rate after reset; parity starts even with one stop bit.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			link_r <= LINK_RESET;
		end else if (wrLink && linkOk) begin
			link_r <= reqData;
		end
	end

	// Selectors take any word; a bad target shows up as a refused read later.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < MAP_SLOTS; i++) begin
				mapSel_r[i] <= `RSM_S_TEMP_C;
			end
		end else if (wrMap) begin
			mapSel_r[cfgSlot] <= reqData;
		end
	end

	// Every request is answered exactly one cycle after it is taken.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rspValid_r <= 1'b0;
		end else begin
			rspValid_r <= reqValid;
		end
	end

	// Data and code hold between answers, so a slow reader still sees them.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rspData_r <= 16'h0000;
		end else if (isRead) begin
			rspData_r <= rdData;
		end else if (isWrite) begin
			rspData_r <= reqData;
		end else if (isOther) begin
			rspData_r <= 16'h0000;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rspExc_r <= `RSM_EX_NONE;
		end else if (isRead) begin
			rspExc_r <= rdExc;
		end else if (isWrite) begin
			rspExc_r <= wrExc;
		end else if (isOther) begin
			rspExc_r <= `RSM_EX_FUNC;
		end
	end

	assign rspValid     = rspValid_r;
	assign rspData      = rspData_r;
	assign rspException = rspExc_r;

	// The switches are combinational here so a change reaches busAddress in the same cycle.
	assign switchesZero = addrSwitch == `RSM_SWITCH_OFF;
	assign busAddress   = switchesZero ? station_r : addrSwitch;

	assign baudSel = rsm_pkg::rsm_baud_t'(link_r[`RSM_LS_BAUD_MSB:`RSM_LS_BAUD_LSB]);

	// BACnet framing is fixed at no parity and one stop bit.
	always_comb begin
		if (bacnetMode) begin
			parityMode = rsm_pkg::RSM_PAR_NONE;
		end else begin
			parityMode = rsm_pkg::rsm_parity_t'(link_r[`RSM_LS_PAR_MSB:`RSM_LS_PAR_LSB]);
		end
	end

	always_comb begin
		if (bacnetMode) begin
			twoStopBits = 1'b0;
		end else begin
			twoStopBits = link_r[`RSM_LS_STOP2];
		end
	end

endmodule

// *** verification/rsm_bank_chk.sv ***
`timescale 1ns/1ps
module rsm_bank_chk (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic [7:0]           addrSwitch,
	input  wire logic                 bacnetMode,
	input  wire logic                 reqValid,
	input  wire logic [7:0]           reqFunc,
	input  wire logic [15:0]          reqAddr,
	input  wire logic [15:0]          reqData,
	input  wire logic [15:0]          statusFlags,
	input  wire logic                 rspValid,
	input  wire logic [15:0]          rspData,
	input  wire logic [7:0]           rspException,
	input  wire logic [7:0]           busAddress,
	input  wire rsm_pkg::rsm_baud_t   baudSel,
	input  wire rsm_pkg::rsm_parity_t parityMode,
	input  wire logic                 twoStopBits
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence wrAt(logic [15:0] a);
		reqValid && reqFunc == 8'h06 && reqAddr == a;
	endsequence
	sequence stnGood;
		wrAt(16'h0000) ##0 reqData inside {[16'h0001:16'h00f7]};
	endsequence
	sequence lnkGood;
		wrAt(16'h0001) ##0 (reqData[2:0] <= 3'h5 && reqData[4:3] != 2'h3);
	endsequence
	AST_RSP_ONE: assert property (reqValid |=> rspValid)
		else $error("request not answered one cycle later");
	AST_RSP_QUIET: assert property (!reqValid |=> !rspValid)
		else $error("answer without a request");
	AST_SW_OVR: assert property (addrSwitch != 8'h00 |-> busAddress == addrSwitch)
		else $error("nonzero switch value not used as bus address");
	AST_STN_WR: assert property (stnGood |=> rspException == 8'h00
		&& (addrSwitch != 8'h00 || {8'h00, busAddress} == $past(reqData)))
		else $error("stored station address not taken from write");
	AST_STN_BAD: assert property (wrAt(16'h0000) ##0 !(reqData inside {[1:247]})
		|=> rspException == 8'h03) else $error("illegal station value accepted");
	AST_LNK_WR: assert property (lnkGood |=> rspException == 8'h00
		&& {13'h0000, baudSel} == ($past(reqData) & 16'h0007))
		else $error("line rate not taken from write");
	AST_BAD_FUNC: assert property (reqValid && !(reqFunc inside {8'h03, 8'h04, 8'h06})
		|=> rspException == 8'h01 && rspData == 16'h0000) else $error("bad function not refused");
	AST_ID_WP: assert property (reqValid && reqFunc == 8'h06
		&& reqAddr inside {[16'h0002:16'h0bb7]} |=> rspException == 8'h02)
		else $error("write into read-only area not refused");
	AST_STATUS: assert property (reqValid && reqFunc == 8'h03 && reqAddr == 16'h0259
		|=> rspData == $past(statusFlags) && rspException == 8'h00)
		else $error("status word read wrong");
	AST_BACNET: assert property (bacnetMode |-> parityMode == rsm_pkg::RSM_PAR_NONE
		&& !twoStopBits) else $error("framing not forced in second personality");
endmodule

bind rsm_register_bank rsm_bank_chk u_chk (.clk, .resetn, .addrSwitch, .bacnetMode, .reqValid,
	.reqFunc, .reqAddr, .reqData, .statusFlags, .rspValid, .rspData, .rspException,
	.busAddress, .baudSel, .parityMode, .twoStopBits);

// *** verification/rsm_master_model.sv ***
`timescale 1ns/1ps
module rsm_master_model (
	input  wire logic        clk,
	output logic             reqValid,
	output logic [7:0]       reqFunc,
	output logic [15:0]      reqAddr,
	output logic [15:0]      reqData,
	input  wire logic        rspValid,
	input  wire logic [15:0] rspData,
	input  wire logic [7:0]  rspException
);
	logic        rdSeen;
	logic [15:0] rdData;
	logic [7:0]  rdExc;
	initial begin
		reqValid = 1'b0;
		reqFunc = 8'h00;
		reqAddr = 16'h0000;
		reqData = 16'h0000;
	end
	// Rate and framing are whatever was last programmed; one master, one setting.
	// Addresses go out zero based. A released bus shows inverted values.
	// One rate and framing for every station on the bus.
	task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
		reqValid <= 1'b1;
		reqFunc <= f;
		reqAddr <= a;
		reqData <= d;
		@(posedge clk);
		reqValid <= 1'b0;
		reqFunc <= ~f;
		reqAddr <= ~a;
		reqData <= ~d;
		@(posedge clk);
		rdSeen = rspValid;
		rdData = rspData;
		rdExc = rspException;
	endtask
endmodule

// *** verification/test_rs485_sensor_register_map.sv ***
`timescale 1ns/1ps
module test_rs485_sensor_register_map;
	logic                 clk = 1'b0;
	logic                 resetn = 1'b0;
	logic [7:0]           addrSwitch = 8'h00;
	logic                 bacnetMode = 1'b0;
	logic [15:0]          statusFlags = 16'h0000;
	logic                 reqValid;
	logic [7:0]           reqFunc;
	logic [15:0]          reqAddr;
	logic [15:0]          reqData;
	logic [31:0]          measFloat [9];
	logic signed [31:0]   measFixed [9];
	logic                 rspValid;
	logic [15:0]          rspData;
	logic [7:0]           rspException;
	logic [7:0]           busAddress;
	rsm_pkg::rsm_baud_t   baudSel;
	rsm_pkg::rsm_parity_t parityMode;
	logic                 twoStopBits;
	logic [31:0]          seed = 32'h88dd4973;
	int                   mismatches = 0;
	int                   check_count = 0;
	// Identity contents are arbitrary; the bench hands them to the bank.
	localparam logic [127:0] SERIAL  = 128'h534e2d30303030303030313233343536;
	localparam logic [127:0] LABEL   = 128'h524f4f4d2053454e534f522042414e4b;
	localparam logic [15:0]  FW_WORD = 16'h0203;
	always #4 clk = ~clk;
	rsm_register_bank #(.SERIAL_TEXT(SERIAL), .LABEL_TEXT(LABEL), .FW_MAJOR(FW_WORD[15:8]),
		.FW_MINOR(FW_WORD[7:0])) dut (.clk, .resetn, .addrSwitch, .bacnetMode, .reqValid, .reqFunc,
		.reqAddr, .reqData, .measFloat, .measFixed, .statusFlags, .rspValid, .rspData,
		.rspException, .busAddress, .baudSel, .parityMode, .twoStopBits);
	rsm_master_model mst (.clk, .reqValid, .reqFunc, .reqAddr, .reqData, .rspValid, .rspData,
		.rspException);
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] scaled(input logic signed [31:0] v, input int sc);
		longint p;
		p = (longint'(v) * sc + 128) >>> 8;
		if (p > 32767) p = 32767;
		if (p < -32768) p = -32768;
		return p[15:0];
	endfunction
	function automatic logic [39:0] measAt(input int i);
		case (i)
			0:       return 40'h03ea0fa164;
			1:       return 40'h03ec0fa232;
			2:       return 40'h03f00fa432;
			3:       return 40'h03fc0faa64;
			4:       return 40'h04240fbe01;
			5:       return 40'h04260fbf01;
			6:       return 40'h04500fd464;
			7:       return 40'h04520fd564;
			default: return 40'h047a0fe964;
		endcase
	endfunction
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic rq(input logic [7:0] f, input logic [15:0] a, d, ed, input logic [7:0] ee);
		mst.xfer(f, a, d);
		chk("answer", 16'h0001, {15'h0000, mst.rdSeen});
		chk("exception", {8'h00, ee}, {8'h00, mst.rdExc});
		if (ee === 8'h00) chk("data", ed, mst.rdData);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
	initial begin
		logic [15:0] a;
		logic [31:0] w;
		logic signed [31:0] s;
		logic [39:0] m;
		for (int i = 0; i < 9; i++) begin
			measFloat[i] = rnd();
			measFixed[i] = rnd();
		end
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chk("station", 16'h002d, {8'h00, busAddress});
		chk("framing", 16'h0010, {10'h000, twoStopBits, parityMode, baudSel});
		for (int i = 0; i < 12; i++) begin
			a = i == 0 ? 16'h0001 : i == 1 ? 16'h00f7 : 16'(rnd() % 247 + 1);
			rq(8'h06, 16'h0000, a, a, 8'h00);
			chk("station", a, {8'h00, busAddress});
		end
		rq(8'h06, 16'h0000, 16'h0000, 16'h0000, 8'h03);
		rq(8'h06, 16'h0000, 16'h00f8, 16'h0000, 8'h03);
		chk("station", a, {8'h00, busAddress});
		for (int i = 0; i < 8; i++) begin
			w = rnd() | 32'h1;
			addrSwitch <= w[7:0];
			@(posedge clk);
			chk("switch", {8'h00, w[7:0]}, {8'h00, busAddress});
		end
		addrSwitch <= 8'h00;
		for (int b = 0; b < 6; b++) for (int p = 0; p < 3; p++) begin
			a = 16'(b + p * 8 + p % 2 * 32);
			rq(8'h06, 16'h0001, a, a, 8'h00);
			chk("framing", a, {10'h000, twoStopBits, parityMode, baudSel});
		end
		rq(8'h06, 16'h0001, 16'h0018, 16'h0000, 8'h03);
		rq(8'h06, 16'h0001, 16'h0006, 16'h0000, 8'h03);
		bacnetMode <= 1'b1;
		@(posedge clk);
		chk("framing", 16'h0005, {10'h000, twoStopBits, parityMode, baudSel});
		bacnetMode <= 1'b0;
		rq(8'h06, 16'h0001, 16'h0010, 16'h0010, 8'h00);
		rq(8'h03, 16'h0008, 16'h0000, FW_WORD, 8'h00);
		for (int i = 0; i < 8; i++) begin
			a = 16'(i);
			rq(i[0] ? 8'h03 : 8'h04, a, 16'h0, SERIAL[127 - 16 * i -: 16], 8'h0);
			rq(i[0] ? 8'h04 : 8'h03, a + 9, 16'h0, LABEL[127 - 16 * i -: 16], 8'h0);
		end
		rq(8'h06, 16'h0008, 16'h1234, 16'h0000, 8'h02);
		rq(8'h10, 16'h0259, 16'h0000, 16'h0000, 8'h01);
		rq(8'h03, 16'h0100, 16'h0000, 16'h0000, 8'h02);
		for (int i = 0; i < 8; i++) begin
			a = rnd();
			statusFlags <= a;
			@(posedge clk);
			rq(i[0] ? 8'h03 : 8'h04, 16'h0259, 16'h0000, a, 8'h00);
		end
		rq(8'h06, 16'h0bd1, 16'h0259, 16'h0259, 8'h00);
		rq(8'h04, 16'h0bb9, 16'h0000, a, 8'h00);
		for (int i = 0; i < 9; i++) begin
			m = measAt(i);
			w = rnd();
			s = $signed(w) >>> 10;
			measFixed[i] <= s;
			measFloat[i] <= w;
			repeat (2) @(posedge clk);
			rq(8'h03, m[39:24], 16'h0000, w[31:16], 8'h00);
			rq(8'h03, m[39:24] + 16'h0001, 16'h0000, w[15:0], 8'h00);
			rq(8'h04, m[23:8], 16'h0000, scaled(s, int'(m[7:0])), 8'h00);
		end
		for (int i = 0; i < 16; i++) begin
			w = rnd();
			s = i == 0 ? 32'sh7fffffff : i == 1 ? 32'sh80000000 : $signed(w) >>> (i[0] ? 12 : 0);
			measFixed[0] <= s;
			measFloat[0] <= w;
			repeat (2) @(posedge clk);
			rq(8'h04, 16'h0fa1, 16'h0000, scaled(s, 100), 8'h00);
			rq(8'h03, 16'h0bb8, 16'h0000, scaled(s, 100), 8'h00);
			rq(8'h03, 16'h03ea, 16'h0000, w[31:16], 8'h00);
			rq(8'h04, 16'h03eb, 16'h0000, w[15:0], 8'h00);
		end
		end_of_test();
	end
endmodule
